// File: verilog/msl_consts.svh
// constants shared by the supervisor core: offsets, reset values, timing
// assumes a single 200 MHz pclk domain and an APB register port
`ifndef MSL_CONSTS_SVH
`define MSL_CONSTS_SVH

// number of monitored rails (largest variant, unused rails held high)
`define MSL_NUM_RAILS 8
// timebase rate in hertz
`define MSL_CLK_HZ 200000000
// least release timeout, milliseconds
`define MSL_RELEASE_MS 140
// watchdog timeout, milliseconds (typical figure)
`define MSL_WDOG_MS 1600
// delay from margin exit to a pending watchdog reset, microseconds
`define MSL_MARGIN_EXIT_US 100

// register byte offsets
`define MSL_OFS_CTRL 12'h000
`define MSL_OFS_STATUS 12'h004
// control field: software manual reset request
`define MSL_CTRL_SWRST 0
// synchroniser reset image: manual reset, margin, kick-open, timeout-set
// and lockout high, everything else low
`define MSL_SYNC_RST 16'h00d5

`endif

// File: verilog/msl_pkg.sv
// types of the supervisor core: pin bundle, state enum, state records
// assumes msl_consts.svh is on the include path
`include "msl_consts.svh"

package msl_pkg;

   // pin bundle, all asynchronous to pclk
   typedef struct packed {
      logic [`MSL_NUM_RAILS-1:0] rail_below;        // 1 = rail under threshold
      logic                      manual_reset_in_n;  // low = manual reset
      logic                      margin_test_n;      // low = margin test
      logic                      watchdog_kick_in;   // any edge is a kick
      logic                      watchdog_kick_open; // 1 = kick pin floating
      logic                      threshold_band_select; // 0 narrow, 1 wide
      logic                      timeout_set_pin;    // 1 = tied to supply
      logic                      ext_timeout_done;   // capacitor ramp done
      logic                      supply_lockout;     // 1 = supply too low
   } msl_pins_type;

   // sequencer states
   typedef enum logic [1:0] {
      MSL_ST_LOCK = 2'b00,
      MSL_ST_HOLD = 2'b01,
      MSL_ST_RUN  = 2'b10
   } msl_state_type;

   // whole state of the core
   typedef struct packed {
      msl_state_type             state;
      logic [31:0]               cnt;       // release hold count
      logic [31:0]               md_cnt;    // margin exit delay count
      logic                      wd_pend;   // expiry seen during margin
      logic                      sw_mr;     // software manual reset
      logic                      rst_n_out;
      logic [`MSL_NUM_RAILS-1:0] rail_ok;
      logic                      band_wide;
      logic                      ramp_en;
      logic [31:0]               prdata;
      logic                      pready;
      logic                      pslverr;
   } msl_core_type;

   // whole state of the watchdog
   typedef struct packed {
      logic        prev_kick;
      logic [31:0] cnt;
      logic        fire;
   } msl_wdog_type;

   // whole state of the synchroniser
   typedef struct packed {
      logic [$bits(msl_pins_type)-1:0] s1;
      logic [$bits(msl_pins_type)-1:0] s2;
   } msl_sync_type;

endpackage : msl_pkg

// File: verilog/msl_sync.sv
// two-flop synchroniser for the whole pin bundle
// assumes pins are asynchronous to pclk; first stage feeds only the second
`include "msl_consts.svh"

module msl_sync #(
   parameter logic [15:0] RST_VAL = `MSL_SYNC_RST
) (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  msl_pkg::msl_pins_type d,
   output msl_pkg::msl_pins_type q
);
   msl_pkg::msl_sync_type st_reg; // both stages
   msl_pkg::msl_sync_type st_next;

   // shift one stage per edge
   always_comb
   begin
      st_next    = st_reg;
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
   end

   // floating pull-up pins come up inactive before any sample
   // margin also comes up high, so supervision starts normal
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg <= {RST_VAL, RST_VAL};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.s2;
endmodule : msl_sync

// File: verilog/msl_wdog.sv
// watchdog counter: any change on the kick level restarts it
// assumes kick and open are already synchronised to pclk
module msl_wdog #(
   parameter int unsigned WD_CYCLES = 32'd1000
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic kick,
   input  wire logic kick_open,
   input  wire logic restart,
   output logic      fire
);
   msl_pkg::msl_wdog_type st_reg; // whole state
   msl_pkg::msl_wdog_type st_next;

   // count timebase ticks since the last kick
   always_comb
   begin
      st_next           = st_reg;
      st_next.fire      = 1'b0;
      st_next.prev_kick = kick;
      if (kick_open || restart || (kick != st_reg.prev_kick))
      begin
         st_next.cnt = 32'h0; // floating pin disables it
      end
      else if (st_reg.cnt == WD_CYCLES - 32'd1)
      begin
         st_next.fire = 1'b1; // one-cycle expiry pulse
         st_next.cnt  = 32'h0;
      end
      else
      begin
         st_next.cnt = st_reg.cnt + 32'd1;
      end
   end

   // register the state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign fire = st_reg.fire;
endmodule : msl_wdog

// File: verilog/msl_supervisor.sv
// multi-rail supervisor core: rail faults, system reset, watchdog, APB
// assumes analog comparators and pins arrive asynchronously; one pclk
`include "msl_consts.svh"

module msl_supervisor #(
   // least release time, rounded up to whole cycles
   parameter int unsigned REL_CYCLES = int'((64'(`MSL_RELEASE_MS)
      * 64'(`MSL_CLK_HZ) + 64'd999) / 64'd1000),
   // watchdog timeout in cycles
   parameter int unsigned WD_CYCLES = int'((64'(`MSL_WDOG_MS)
      * 64'(`MSL_CLK_HZ)) / 64'd1000),
   // margin exit delay in cycles
   parameter int unsigned MD_CYCLES = int'((64'(`MSL_MARGIN_EXIT_US)
      * 64'(`MSL_CLK_HZ)) / 64'd1000000)
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [11:0]               paddr,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  msl_pkg::msl_pins_type          pins,
   output logic                           sys_reset_n,
   output logic      [`MSL_NUM_RAILS-1:0] rail_ok,
   output logic                           band_wide,
   output logic                           ramp_en
);

   msl_pkg::msl_core_type st_reg;   // whole state
   msl_pkg::msl_core_type st_next;  // its next value
   msl_pkg::msl_pins_type pin_s;    // synchronised pins
   logic                  wd_fire;  // watchdog expiry pulse
   logic                  wd_now;   // watchdog reset to act on now
   logic                  fault_now; // any reason to hold reset other than supply lockout
   logic                  rel_done; // release timeout reached
   logic                  addr_ok;  // address hits a register
   logic                  wr_ctrl;  // completed write to control

   // every pin goes through two flops before use
   msl_sync #(
      .RST_VAL (`MSL_SYNC_RST)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (pins),
      .q       (pin_s)
   );

   // watchdog restarts whenever reset is being held
   msl_wdog #(
      .WD_CYCLES (WD_CYCLES)
   ) u_wdog (
      .pclk      (pclk),
      .presetn   (presetn),
      .kick      (pin_s.watchdog_kick_in),
      .kick_open (pin_s.watchdog_kick_open),
      .restart   (st_reg.state != msl_pkg::MSL_ST_RUN),
      .fire      (wd_fire)
   );

   // next-state logic for bus, watchdog, sequencer and outputs
   always_comb
   begin
      st_next         = st_reg;
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      wd_now          = 1'b0;
      addr_ok = (paddr == `MSL_OFS_CTRL) || (paddr == `MSL_OFS_STATUS);
      wr_ctrl = psel && penable && st_reg.pready && pwrite
                && (paddr == `MSL_OFS_CTRL) && pstrb[0];

      // setup phase: prepare the one-cycle answer
      if (psel && !penable)
      begin
         st_next.pready  = 1'b1;
         st_next.pslverr = !addr_ok; // unmapped address errors
         if (!pwrite && (paddr == `MSL_OFS_CTRL))
         begin
            st_next.prdata = {31'h0, st_reg.sw_mr};
         end
         else if (!pwrite && (paddr == `MSL_OFS_STATUS))
         begin
            st_next.prdata = {18'h0,
                              pin_s.rail_below,
                              st_reg.rst_n_out,
                              pin_s.supply_lockout,
                              !pin_s.margin_test_n,
                              pin_s.watchdog_kick_open,
                              st_reg.wd_pend,
                              st_reg.band_wide};
         end
         else
         begin
            st_next.prdata = 32'h0; // writes and misses read zero
         end
      end

      // software manual reset bit, taken at the completing edge
      if (wr_ctrl)
      begin
         st_next.sw_mr = pwdata[`MSL_CTRL_SWRST];
      end

      // watchdog: expiry inside margin waits for margin exit
      if (wd_fire)
      begin
         if (!pin_s.margin_test_n)
         begin
            st_next.wd_pend = 1'b1;
         end
         else
         begin
            wd_now = 1'b1;
         end
      end
      if (!pin_s.margin_test_n)
      begin
         st_next.md_cnt = 32'h0; // delay counts from margin exit
      end
      else if (st_reg.wd_pend)
      begin
         if (st_reg.md_cnt == MD_CYCLES - 32'd1)
         begin
            wd_now          = 1'b1; // delayed watchdog reset
            st_next.wd_pend = 1'b0;
            st_next.md_cnt  = 32'h0;
         end
         else
         begin
            st_next.md_cnt = st_reg.md_cnt + 32'd1;
         end
      end

      // reasons to hold reset
      fault_now = (|pin_s.rail_below) || !pin_s.manual_reset_in_n
                  || st_reg.sw_mr || wd_now;

      // internal timer or external capacitor ramp
      rel_done = pin_s.timeout_set_pin ? (st_reg.cnt == REL_CYCLES - 32'd1)
                                       : pin_s.ext_timeout_done;

      // reset sequencer
      unique case (st_reg.state)
         msl_pkg::MSL_ST_LOCK:
         begin
            // lockout gone: evaluate everything afresh
            st_next.state = msl_pkg::MSL_ST_HOLD;
            st_next.cnt   = 32'h0;
         end
         msl_pkg::MSL_ST_HOLD:
         begin
            if (fault_now)
            begin
               st_next.cnt = 32'h0; // bounce restarts the hold
            end
            else if (rel_done)
            begin
               st_next.state = msl_pkg::MSL_ST_RUN;
            end
            else
            begin
               st_next.cnt = st_reg.cnt + 32'd1;
            end
         end
         msl_pkg::MSL_ST_RUN:
         begin
            if (fault_now)
            begin
               st_next.state = msl_pkg::MSL_ST_HOLD;
               st_next.cnt   = 32'h0;
            end
         end
      endcase

      // lockout overrides the sequencer and drops pending work
      if (pin_s.supply_lockout)
      begin
         st_next.state   = msl_pkg::MSL_ST_LOCK;
         st_next.cnt     = 32'h0;
         st_next.wd_pend = 1'b0;
      end

      // ramp the external capacitor only while a hold is running
      st_next.ramp_en = (st_next.state == msl_pkg::MSL_ST_HOLD)
                        && !fault_now && !pin_s.timeout_set_pin;

      // band select straight through to the comparators
      st_next.band_wide = pin_s.threshold_band_select;

      // output priority: lockout, then margin, then supervision
      if (pin_s.supply_lockout)
      begin
         st_next.rst_n_out = 1'b0;
         st_next.rail_ok   = '0;
      end
      else if (!pin_s.margin_test_n)
      begin
         // forced high, hence frozen, whatever the rails do
         st_next.rst_n_out = 1'b1;
         st_next.rail_ok   = '1;
      end
      else
      begin
         st_next.rst_n_out = (st_next.state == msl_pkg::MSL_ST_RUN);
         st_next.rail_ok   = ~pin_s.rail_below; // per rail
      end
   end

   // single state register; reset drives sys_reset_n, rail_ok, band_wide and ramp_en low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // outputs come straight from the state flops
   assign prdata      = st_reg.prdata;
   assign pready      = st_reg.pready;
   assign pslverr     = st_reg.pslverr;
   assign sys_reset_n = st_reg.rst_n_out;
   assign rail_ok     = st_reg.rail_ok;
   assign band_wide   = st_reg.band_wide;
   assign ramp_en     = st_reg.ramp_en;

   // checks share the pclk domain and its reset
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_lockout_forces: assert property (
      pin_s.supply_lockout |=> !sys_reset_n && (rail_ok == '0))
      else $error("lockout did not force outputs low");

   chk_rail_follow: assert property (
      (!pin_s.supply_lockout && pin_s.margin_test_n)
      |=> rail_ok == ~$past(pin_s.rail_below))
      else $error("fault output does not follow its rail");

   chk_margin_high: assert property (
      (!pin_s.supply_lockout && !pin_s.margin_test_n)
      |=> sys_reset_n && (rail_ok == '1))
      else $error("margin test did not force outputs high");

   chk_margin_frozen: assert property (
      (!pin_s.supply_lockout && !pin_s.margin_test_n) ##1
      (!pin_s.supply_lockout && !pin_s.margin_test_n)
      |=> $stable(sys_reset_n) && $stable(rail_ok))
      else $error("output changed during margin test");

   chk_fault_asserts: assert property (
      (fault_now && pin_s.margin_test_n && !pin_s.supply_lockout)
      |=> !sys_reset_n)
      else $error("fault did not assert reset");

   chk_hold_length: assert property (
      ($rose(sys_reset_n) && $past(pin_s.margin_test_n)
       && $past(pin_s.timeout_set_pin))
      |-> $past(st_reg.cnt) == REL_CYCLES - 32'd1)
      else $error("reset released before full timeout");

   chk_bounce_restart: assert property (
      (!pin_s.manual_reset_in_n && !pin_s.supply_lockout)
      |=> (st_reg.cnt == 32'h0) && (st_reg.state == msl_pkg::MSL_ST_HOLD))
      else $error("manual reset did not restart the hold");

   chk_wdog_fire: assert property (
      (wd_fire && pin_s.margin_test_n && !pin_s.supply_lockout)
      |=> !sys_reset_n)
      else $error("watchdog expiry did not assert reset");

   chk_wdog_open: assert property (
      $past(pin_s.watchdog_kick_open) && pin_s.watchdog_kick_open
      |-> !wd_fire)
      else $error("watchdog fired while disabled");

   chk_margin_exit: assert property (
      (st_reg.wd_pend && pin_s.margin_test_n && !pin_s.supply_lockout
       && (st_reg.md_cnt == MD_CYCLES - 32'd1))
      |=> !sys_reset_n)
      else $error("pending watchdog reset missed after margin");

endmodule : msl_supervisor

// File: testbench/msl_host_model.sv
// host model: takes the system reset and kicks the watchdog
// assumes one pclk; the host kicks only out of reset and when enabled
module msl_host_model #(
   parameter int unsigned GAP = 30  // cycles between kick edges
) (
   input  wire logic pclk,
   input  wire logic sys_reset_n,
   input  wire logic kick_en,
   output logic      kick
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned cnt   = 0;    // cycles since the last kick edge
   logic        level = 1'b0; // kick level, idle low like the pin
   assign kick = level;
   // a held reset halts the host, so a stalled host stops kicking
   always @(posedge pclk)
   begin
      if (!sys_reset_n || !kick_en)
         cnt <= 0;
      else if (cnt == GAP - 1)
      begin
         cnt  <= 0;
         level <= ~level;
      end
      else
         cnt <= cnt + 1;
   end
endmodule : msl_host_model

// File: testbench/msl_supervisor_tb_top.sv
// self-checking bench of the supervisor core with a kicking host
// assumes short counts: hold 20, watchdog 100, margin exit delay 5
module msl_supervisor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int REL = 20;  // release hold in cycles
   localparam int WD  = 100; // watchdog timeout in cycles
   localparam int MD  = 5;   // margin exit delay in cycles
   logic        pclk = 0, presetn = 0;
   logic        psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic        pready, pslverr, err;
   logic        sys_reset_n, band_wide, ramp_en, kick;
   logic [7:0]  rail_ok, rail_below = '0;  // unused rails held high
   logic        mr_n = 1, mg_n = 1, kopen = 0, band = 0;
   logic        tset = 1, extd = 0, lock = 1, kick_en = 1;
   msl_pkg::msl_pins_type pins;
   int fail_count = 0, n_compared = 0, n;
   assign pins = {rail_below, mr_n, mg_n, kick, kopen, band, tset,
                  extd, lock};
   // 200 MHz clock
   initial forever #2.5 pclk = ~pclk;
   msl_supervisor #(.REL_CYCLES(REL), .WD_CYCLES(WD), .MD_CYCLES(MD))
      i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins(pins), .sys_reset_n(sys_reset_n),
      .rail_ok(rail_ok), .band_wide(band_wide), .ramp_en(ramp_en));
   msl_host_model i_host (.pclk(pclk), .sys_reset_n(sys_reset_n),
      .kick_en(kick_en), .kick(kick));
   // verdict, also reached by a spent wait
   task automatic complete_run;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   function automatic logic [31:0] in_rng(int v, int lo, int hi);
      return {31'h0, v >= lo && v <= hi};
   endfunction : in_rng
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask : cyc
   // bounded wait for the system reset to reach a level
   task automatic wait_rst(input logic v, output int k);
      k = 0;
      while (sys_reset_n !== v)
      begin
         @(posedge pclk);
         k++;
         if (k > 3000)
         begin
            chk("reset wait", 32'h1, 32'h0);
            complete_run();
         end
      end
   endtask : wait_rst
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do
      begin
         @(posedge pclk);
         k++;
         if (k > 50)
         begin
            chk("pready wait", 32'h1, 32'h0);
            complete_run();
         end
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic t_power;
      cyc(10);
      chk("rst in lockout", 32'h0, {31'h0, sys_reset_n});
      chk("rail_ok in lockout", 32'h0, {24'h0, rail_ok});
      @(posedge pclk) lock <= 0;
      wait_rst(1'b1, n);
      chk("power-up release", 32'h1, in_rng(n, REL, REL + 10));
      chk("rail_ok after lockout", 32'hff, {24'h0, rail_ok});
      $display("test power done");
   endtask : t_power
   // one rail after another, back to back, so each restarts the hold
   task automatic t_rail;
      for (int i = 0; i < 8; i++)
      begin
         @(posedge pclk) rail_below <= 8'h01 << i;
         cyc(4);
         chk("rail_ok", {24'h0, ~(8'h01 << i)}, {24'h0, rail_ok});
         chk("rst on rail", 32'h0, {31'h0, sys_reset_n});
      end
      @(posedge pclk) rail_below <= 8'h00;
      wait_rst(1'b1, n);
      chk("rail release", 32'h1, in_rng(n, REL, REL + 10));
      chk("rail_ok all", 32'hff, {24'h0, rail_ok});
      $display("test rail done");
   endtask : t_rail
   // bounce shorter than the hold must not let reset go early
   task automatic t_manual;
      @(posedge pclk) mr_n <= 0;
      cyc(4);
      chk("rst on manual", 32'h0, {31'h0, sys_reset_n});
      repeat (6)
      begin
         @(posedge pclk) mr_n <= ~mr_n;
         cyc(3);
      end
      @(posedge pclk) mr_n <= 1;
      wait_rst(1'b1, n);
      chk("manual release", 32'h1, in_rng(n, REL, REL + 10));
      $display("test manual done");
   endtask : t_manual
   task automatic t_wdog;
      @(posedge pclk) kick_en <= 0;
      wait_rst(1'b0, n);
      chk("watchdog expiry", 32'h1, in_rng(n, WD - 40, WD + 10));
      @(posedge pclk) kick_en <= 1;
      wait_rst(1'b1, n);
      @(posedge pclk) kopen <= 1;
      kick_en <= 0;
      // every cycle must keep reset released, not only the last one
      n = 0;
      repeat (3 * WD)
      begin
         @(posedge pclk);
         if (sys_reset_n !== 1'b1)
            n++;
      end
      chk("open kick pin", 32'h0, n);
      @(posedge pclk) kick_en <= 1;
      kopen <= 0;
      $display("test watchdog done");
   endtask : t_wdog
   task automatic t_margin;
      @(posedge pclk) mg_n <= 0;
      cyc(4);
      @(posedge pclk) rail_below <= 8'hff;
      cyc(6);
      chk("margin rst", 32'h1, {31'h0, sys_reset_n});
      chk("margin rail_ok", 32'hff, {24'h0, rail_ok});
      @(posedge pclk) rail_below <= 8'h00;
      kick_en <= 0;
      // outputs must stay high on every cycle while the watchdog runs out
      n = 0;
      repeat (2 * WD)
      begin
         @(posedge pclk);
         if (sys_reset_n !== 1'b1 || rail_ok !== 8'hff)
            n++;
      end
      chk("margin frozen", 32'h0, n);
      apb(1'b0, 12'h004, 32'h0);
      chk("pending flag", 32'h0a, rd & 32'h0000000a);
      @(posedge pclk) mg_n <= 1;
      kick_en <= 1;
      wait_rst(1'b0, n);
      chk("margin exit delay", 32'h1, in_rng(n, MD, MD + 6));
      wait_rst(1'b1, n);
      $display("test margin done");
   endtask : t_margin
   // lockout wins over margin
   task automatic t_lock;
      @(posedge pclk) lock <= 1;
      mg_n <= 0;
      cyc(4);
      chk("lockout rst", 32'h0, {31'h0, sys_reset_n});
      chk("lockout rail_ok", 32'h0, {24'h0, rail_ok});
      @(posedge pclk) lock <= 0;
      mg_n <= 1;
      wait_rst(1'b1, n);
      $display("test lockout done");
   endtask : t_lock
   task automatic t_ext;
      @(posedge pclk) tset <= 0;
      mr_n <= 0;
      cyc(4);
      @(posedge pclk) mr_n <= 1;
      cyc(3 * REL);
      chk("ext hold rst", 32'h0, {31'h0, sys_reset_n});
      chk("ramp_en", 32'h1, {31'h0, ramp_en});
      @(posedge pclk) extd <= 1;
      wait_rst(1'b1, n);
      chk("ext release", 32'h1, in_rng(n, 1, 8));
      chk("ramp_en off", 32'h0, {31'h0, ramp_en});
      @(posedge pclk) tset <= 1;
      extd <= 0;
      $display("test ext timeout done");
   endtask : t_ext
   task automatic t_apb;
      @(posedge pclk) band <= 1;
      cyc(4);
      chk("band_wide", 32'h1, {31'h0, band_wide});
      apb(1'b0, 12'h004, 32'h0);
      chk("status", 32'h21, rd);
      @(posedge pclk) band <= 0;
      cyc(4);
      chk("band_wide", 32'h0, {31'h0, band_wide});
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, 12'h004, 32'h1);
      chk("status write err", 32'h0, {31'h0, err});
      apb(1'b1, 12'h000, 32'h1);
      cyc(4);
      chk("sw reset", 32'h0, {31'h0, sys_reset_n});
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl readback", 32'h1, rd);
      apb(1'b1, 12'h000, 32'h0);
      wait_rst(1'b1, n);
      chk("sw release", 32'h1, in_rng(n, REL, REL + 10));
      $display("test apb done");
   endtask : t_apb
   // mid-run reset: outputs asserted, then a fresh power-up release
   task automatic t_reset;
      @(posedge pclk) presetn <= 0;
      cyc(2);
      chk("rst in reset", 32'h0, {31'h0, sys_reset_n});
      chk("rail_ok in reset", 32'h0, {24'h0, rail_ok});
      @(posedge pclk) presetn <= 1;
      wait_rst(1'b1, n);
      chk("reset release", 32'h1, in_rng(n, REL, REL + 10));
      $display("test reset done");
   endtask : t_reset
   // main sequence
   initial
   begin
      cyc(2);
      presetn <= 1;
      t_power();
      t_rail();
      t_manual();
      t_wdog();
      t_margin();
      t_lock();
      t_ext();
      t_apb();
      t_reset();
      complete_run();
   end
endmodule : msl_supervisor_tb_top
